// File: src/bcs_pkg.sv
// bcs_pkg: constants, codes and state type of the boot configuration sequencer
// assumes a single 125 MHz clock domain; imported by all three design files and by the simulation files
package bcs_pkg;

	// clock and timing
	localparam int unsigned CLK_HZ       = 125_000_000;
	localparam int unsigned READY_TIME_MS = 3000;
	localparam int unsigned READY_CYC    = READY_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned MIC_CLK_HZ   = 6_144_000;
	localparam logic [2:0]  START_DLY    = 3'h4;

	// synchroniser width: strap and boot select pins
	localparam int unsigned PIN_W        = 2;
	localparam int unsigned PIN_SPI_BOOT = 0;
	localparam int unsigned PIN_BOOT_SEL = 1;

	// command codes, shared by stored configuration and host control
	localparam logic [3:0] CMD_MIC_DIV  = 4'h1;
	localparam logic [3:0] CMD_I2S_RATE = 4'h2;
	localparam logic [3:0] CMD_MIC_GO   = 4'h3;
	localparam logic [3:0] CMD_I2S_GO   = 4'h4;
	localparam logic [3:0] CMD_VID      = 4'h5;
	localparam logic [3:0] CMD_PID      = 4'h6;

	// boot outcome codes
	localparam logic [7:0] RS_NONE            = 8'h00;
	localparam logic [7:0] RS_FACTORY_OK      = 8'h01;
	localparam logic [7:0] RS_UPGRADE_OK      = 8'h02;
	localparam logic [7:0] RS_FACTORY_DEFAULT = 8'h03;
	localparam logic [7:0] RS_UPGRADE_DEFAULT = 8'h04;
	localparam logic [7:0] RS_SPI_OK          = 8'h05;
	localparam logic [7:0] RS_FAIL_IMAGE      = 8'h10;
	localparam logic [7:0] RS_FAIL_TIMEOUT    = 8'h11;
	localparam logic [7:0] RS_FAIL_SPI        = 8'h12;

	// values after reset; identity codes are arbitrary neutral values
	localparam logic [15:0] MIC_DIV_RST  = 16'h0001;
	localparam logic [15:0] I2S_RATE_RST = 16'hBB80;
	localparam logic [15:0] VID_DEFAULT  = 16'h1234;
	localparam logic [15:0] PID_DEFAULT  = 16'h0042;

	typedef enum logic [2:0] {
		ST_START   = 3'b000,
		ST_FL_HDR  = 3'b001,
		ST_FL_CMDS = 3'b010,
		ST_SPI     = 3'b011,
		ST_DELAYED = 3'b100,
		ST_RUN     = 3'b101,
		ST_FAIL    = 3'b110
	} bcs_state_t;

endpackage : bcs_pkg

// File: src/bcs_pin_if.sv
// bcs_pin_if: raw pins and their debounced levels between top and synchroniser
// assumes the raw side comes straight from package pins
`timescale 1ns/1ps
interface bcs_pin_if;
	import bcs_pkg::*;
	logic [PIN_W-1:0] raw;
	logic [PIN_W-1:0] level;
	modport sync_mp (input raw, output level);
	modport user_mp (output raw, input level);
endinterface : bcs_pin_if

// File: src/bcs_pin_sync.sv
// bcs_pin_sync: three-stage synchroniser; level follows once stages two and three agree
// assumes pins are asynchronous to ref_clk
`timescale 1ns/1ps
module bcs_pin_sync
	import bcs_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// pins
	bcs_pin_if.sync_mp pins
);
	typedef struct packed {
		logic [PIN_W-1:0] s1;
		logic [PIN_W-1:0] s2;
		logic [PIN_W-1:0] s3;
		logic [PIN_W-1:0] level;
	} bcs_sync_t;

	bcs_sync_t st_r;
	bcs_sync_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pins.raw;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// first stage feeds only the second; agreement filters single glitches
		for (int i = 0; i < PIN_W; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.level[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pins.level = st_r.level;
endmodule : bcs_pin_sync

// File: src/bcs_boot_seq.sv
// bcs_boot_seq: boot configuration sequencer, flash or spi slave boot, delayed start
// assumes image loader, partition reader and control decoder run on ref_clk
// Contract
// (R1) compare image version with partition compatibility version before reading commands
// (R2) on mismatch skip the partition and keep built-in defaults
// (R3) success records distinct codes for factory and upgrade images
// (R4) failed boot enters fail-safe mode and leaves a diagnostic code
// (R5) fail-safe presents default vendor and product codes
// (R6) spi slave boot receives the whole image from the host
// (R7) after spi boot no stored partition is read
// (R8) host releases boot select before sending the image for delayed start
// (R9) after spi boot, boot select asserted starts audio pipelines directly
// (R10) boot select released holds audio until mic and serial-audio start commands
// (R11) host sets mic divider and sample rate before the start commands
// (R12) control commands accepted within 3 seconds after spi image completes
// (R13) mic divider derives the 6.144MHz ddr mic clock from master clock
// (R14) serial audio rate defaults to 48000Hz unless host overrides
// (R15) usb variant has no delayed start and locks usb settings after spi boot
// (R16) host pauses after first spi block for pll and network settling
// (R17) flash boot runs stored commands before normal operation
// (R18) boot outcome stays readable until next reset
`timescale 1ns/1ps
module bcs_boot_seq
	import bcs_pkg::*;
#(
	parameter int unsigned READY_LIMIT_CYC = READY_CYC
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// pins and variant
	input  wire logic        spi_boot_strap,
	input  wire logic        boot_source_select_pin,
	input  wire logic        usb_variant,
	// flash image and partition header
	input  wire logic        image_is_upgrade,
	input  wire logic [15:0] image_version,
	input  wire logic        image_bad,
	input  wire logic        hdr_valid,
	input  wire logic [15:0] hdr_compat_version,
	// stored configuration command stream
	input  wire logic        cfg_valid,
	input  wire logic [3:0]  cfg_code,
	input  wire logic [15:0] cfg_value,
	input  wire logic        cfg_last,
	output logic             cfg_ready,
	// spi slave image loader
	input  wire logic        spi_image_done,
	input  wire logic        spi_image_bad,
	// host control commands
	input  wire logic        ctl_valid,
	input  wire logic [3:0]  ctl_code,
	input  wire logic [15:0] ctl_value,
	output logic             ctl_ready,
	// status and settings
	output logic [7:0]       run_status,
	output logic             fail_safe,
	output logic             booted_spi,
	output logic [15:0]      vendor_id,
	output logic [15:0]      product_id,
	output logic [15:0]      mic_clock_divider,
	output logic [15:0]      i2s_rate,
	output logic             mic_run,
	output logic             i2s_run
);
	typedef struct packed {
		bcs_state_t  state;
		logic [2:0]  start_cnt;
		logic [31:0] wait_cnt;
		logic        spi;
		logic        fail;
		logic [7:0]  status;
		logic [15:0] vid;
		logic [15:0] pid;
		logic [15:0] mic_div;
		logic [15:0] rate;
		logic        mic_go;
		logic        i2s_go;
	} bcs_seq_t;

	bcs_seq_t st_r;
	bcs_seq_t st_nxt;
	bcs_pin_if pins ();

	assign pins.raw[PIN_SPI_BOOT] = spi_boot_strap;
	assign pins.raw[PIN_BOOT_SEL] = boot_source_select_pin;

	bcs_pin_sync u_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.pins    (pins)
	);

	// applies one configuration command; usb settings are frozen after a spi boot on the usb variant
	function automatic bcs_seq_t apply_cmd(input bcs_seq_t s, input logic [3:0] code,
			input logic [15:0] val, input logic lock_usb);
		bcs_seq_t r;
		r = s;
		unique case (code)
			CMD_MIC_DIV:  r.mic_div = val; // R13
			CMD_I2S_RATE: if (!lock_usb) r.rate = val; // R15
			CMD_MIC_GO:   r.mic_go = val[0];
			CMD_I2S_GO:   r.i2s_go = val[0];
			CMD_VID:      if (!lock_usb) r.vid = val; // R15
			CMD_PID:      if (!lock_usb) r.pid = val; // R15
			default:      r = s;
		endcase
		return r;
	endfunction : apply_cmd

	always_comb begin
		st_nxt = st_r;
		unique case (st_r.state)
			ST_START: begin
				// let the strap settle through the synchroniser before deciding
				if (st_r.start_cnt == START_DLY) begin
					if (pins.level[PIN_SPI_BOOT]) begin
						st_nxt.state = ST_SPI; // R6
						st_nxt.spi   = 1'b1;
					end else begin
						st_nxt.state = ST_FL_HDR;
					end
				end else begin
					st_nxt.start_cnt = st_r.start_cnt + 3'h1;
				end
			end
			ST_FL_HDR: begin
				if (image_bad) begin
					st_nxt.state  = ST_FAIL; // R4
					st_nxt.status = RS_FAIL_IMAGE;
				end else if (hdr_valid) begin
					if (hdr_compat_version == image_version) begin // R1
						st_nxt.state    = ST_FL_CMDS;
						st_nxt.wait_cnt = '0;
					end else begin
						st_nxt.state  = ST_RUN; // R2
						st_nxt.status = image_is_upgrade ? RS_UPGRADE_DEFAULT : RS_FACTORY_DEFAULT;
					end
				end
			end
			ST_FL_CMDS: begin
				// the limit runs from entry, so it also caps a long but healthy stream
				st_nxt.wait_cnt = st_r.wait_cnt + 32'h1;
				if (cfg_valid) begin
					st_nxt = apply_cmd(st_nxt, cfg_code, cfg_value, 1'b0); // R17
					if (cfg_last) begin
						st_nxt.state  = ST_RUN; // R17
						st_nxt.status = image_is_upgrade ? RS_UPGRADE_OK : RS_FACTORY_OK; // R3
					end
				end else if (st_r.wait_cnt >= READY_LIMIT_CYC - 1) begin
					// a stalled partition would otherwise hang the boot forever
					st_nxt.state  = ST_FAIL; // R4
					st_nxt.status = RS_FAIL_TIMEOUT;
				end
			end
			ST_SPI: begin
				// no partition read on this path; defaults stay until the host writes
				if (spi_image_bad) begin
					st_nxt.state  = ST_FAIL; // R4
					st_nxt.status = RS_FAIL_SPI;
				end else if (spi_image_done) begin
					st_nxt.status = RS_SPI_OK; // R7
					if (pins.level[PIN_BOOT_SEL] || usb_variant) begin
						st_nxt.state = ST_RUN; // R9 R15
					end else begin
						st_nxt.state = ST_DELAYED; // R10
					end
				end
			end
			ST_DELAYED: begin
				if (ctl_valid) begin
					st_nxt = apply_cmd(st_nxt, ctl_code, ctl_value, 1'b0);
				end
				if (st_nxt.mic_go && st_nxt.i2s_go) begin
					st_nxt.state = ST_RUN; // R10
				end
			end
			ST_RUN: begin
				if (ctl_valid) begin
					st_nxt = apply_cmd(st_nxt, ctl_code, ctl_value, st_r.spi && usb_variant);
				end
				st_nxt.mic_go = 1'b1;
				st_nxt.i2s_go = 1'b1;
			end
			ST_FAIL: begin
				st_nxt.fail = 1'b1;
				st_nxt.vid  = VID_DEFAULT; // R5
				st_nxt.pid  = PID_DEFAULT; // R5
			end
			default: st_nxt.state = ST_FAIL;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_r           <= '0;
			st_r.state     <= ST_START;
			st_r.status    <= RS_NONE; // R18
			st_r.vid       <= VID_DEFAULT;
			st_r.pid       <= PID_DEFAULT;
			st_r.mic_div   <= MIC_DIV_RST;
			st_r.rate      <= I2S_RATE_RST; // R14
		end else begin
			st_r <= st_nxt;
		end
	end

	// control is taken as soon as the boot settles, well inside the ready limit
	assign ctl_ready         = (st_r.state == ST_DELAYED) || (st_r.state == ST_RUN); // R12
	assign cfg_ready         = (st_r.state == ST_FL_CMDS);
	assign run_status        = st_r.status; // R18
	assign fail_safe         = st_r.fail;
	assign booted_spi        = st_r.spi;
	assign vendor_id         = st_r.vid;
	assign product_id        = st_r.pid;
	assign mic_clock_divider = st_r.mic_div;
	assign i2s_rate          = st_r.rate;
	// go bits left by a failed stream are masked outside the run states
	assign mic_run           = st_r.mic_go && (st_r.state == ST_RUN || st_r.state == ST_DELAYED);
	assign i2s_run           = st_r.i2s_go && (st_r.state == ST_RUN || st_r.state == ST_DELAYED);
endmodule : bcs_boot_seq

// File: sim/bcs_boot_seq_props.sv
// bcs_boot_seq_props: concurrent checks on the sequencer top ports
// assumes one ref_clk domain and an active-high async reset
`timescale 1ns/1ps
module bcs_boot_seq_props
	import bcs_pkg::*;
#(
	parameter int unsigned READY_LIMIT_CYC = READY_CYC
) (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        reset,
	// boot context
	input wire logic        image_is_upgrade,
	input wire logic        usb_variant,
	input wire logic        fail_safe,
	input wire logic        booted_spi,
	// stored command stream
	input wire logic        cfg_valid,
	input wire logic        cfg_ready,
	input wire logic        cfg_last,
	input wire logic [3:0]  cfg_code,
	input wire logic [15:0] cfg_value,
	// host control
	input wire logic        ctl_valid,
	input wire logic        ctl_ready,
	input wire logic [3:0]  ctl_code,
	// status and settings
	input wire logic [15:0] vendor_id,
	input wire logic [15:0] product_id,
	input wire logic [15:0] mic_clock_divider,
	input wire logic [15:0] i2s_rate,
	input wire logic [7:0]  run_status
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	cfg_div_a: assert property (
		cfg_valid && cfg_ready && cfg_code == CMD_MIC_DIV |=> mic_clock_divider == $past(cfg_value))
		else $error("stored divider not applied");
	ok_code_a: assert property (
		cfg_valid && cfg_ready && cfg_last
		|=> run_status == ($past(image_is_upgrade) ? RS_UPGRADE_OK : RS_FACTORY_OK))
		else $error("wrong success code");
	dflt_keep_a: assert property (
		$rose(run_status == RS_FACTORY_DEFAULT || run_status == RS_UPGRADE_DEFAULT)
		|-> !cfg_ready && mic_clock_divider == MIC_DIV_RST) else $error("partition read on mismatch");
	spi_nocfg_a: assert property (booted_spi |-> !cfg_ready)
		else $error("partition read after spi boot");
	fs_ids_a: assert property (
		fail_safe ##1 fail_safe |-> vendor_id == VID_DEFAULT && product_id == PID_DEFAULT)
		else $error("custom ids in fail-safe");
	fs_noctl_a: assert property (
		fail_safe |-> !ctl_ready && run_status >= RS_FAIL_IMAGE) else $error("fail-safe state wrong");
	status_hold_a: assert property (run_status != RS_NONE |=> $stable(run_status))
		else $error("boot outcome changed");
	usb_lock_a: assert property (
		usb_variant && booted_spi && ctl_valid && ctl_ready && ctl_code == CMD_I2S_RATE
		|=> $stable(i2s_rate)) else $error("usb rate changed");
endmodule : bcs_boot_seq_props

bind bcs_boot_seq bcs_boot_seq_props #(.READY_LIMIT_CYC(READY_LIMIT_CYC)) i_bcs_boot_seq_props (
	.ref_clk, .reset, .image_is_upgrade, .usb_variant, .fail_safe, .booted_spi, .cfg_valid,
	.cfg_ready, .cfg_last, .ctl_valid, .ctl_ready, .cfg_code, .ctl_code, .cfg_value, .vendor_id,
	.product_id, .mic_clock_divider, .i2s_rate, .run_status);

// File: sim/bcs_flash_model.sv
// bcs_flash_model: stored partition played back as a command stream
// assumes a word is taken when cfg_valid and cfg_ready meet at an edge
`timescale 1ns/1ps
module bcs_flash_model
	import bcs_pkg::*;
(
	// clock and control
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        start,
	input  wire logic        stall,
	// command stream
	input  wire logic        cfg_ready,
	output logic             cfg_valid,
	output logic [3:0]       cfg_code,
	output logic [15:0]      cfg_value,
	output logic             cfg_last
);
	logic [19:0] tbl [3];
	logic [1:0]  idx_r = 2'h0;
	logic        act_r = 1'b0;
	// vendor code first, so a later stall leaves a custom value to undo
	assign tbl[0] = {CMD_VID, 16'h5A5A};
	assign tbl[1] = {CMD_MIC_DIV, 16'h0002};
	assign tbl[2] = {CMD_I2S_RATE, 16'h3E80};
	assign cfg_valid = act_r && !(stall && idx_r != 2'h0);
	// idle lines show the inverse, never a stale word
	assign {cfg_code, cfg_value} = cfg_valid ? tbl[idx_r] : ~tbl[idx_r];
	assign cfg_last = idx_r == 2'h2;
	always @(posedge ref_clk or posedge reset) begin
		if (reset)
			act_r <= 1'b0;
		else if (start) begin
			act_r <= 1'b1;
			idx_r <= 2'h0;
		end else if (cfg_valid && cfg_ready) begin
			act_r <= !cfg_last;
			idx_r <= cfg_last ? idx_r : idx_r + 2'h1;
		end
	end
endmodule : bcs_flash_model

// File: sim/tb.sv
// tb: flash and spi boots of the sequencer against a stored-command model
// assumes design, checker and model are compiled first
`timescale 1ns/1ps
module tb;
	import bcs_pkg::*;
	logic ref_clk = 1'b0, reset = 1'b1, spi_boot_strap = 1'b0, boot_source_select_pin = 1'b0;
	logic usb_variant = 1'b0, image_is_upgrade = 1'b0, image_bad = 1'b0, hdr_valid = 1'b0;
	logic spi_image_done = 1'b0, spi_image_bad = 1'b0, ctl_valid = 1'b0, start = 1'b0;
	logic stall = 1'b0;
	logic [15:0] image_version = 16'h0573, hdr_compat_version = 16'h0573, ctl_value = 16'h0000;
	logic [3:0]  ctl_code = 4'h0, cfg_code;
	logic [15:0] cfg_value, vendor_id, product_id, mic_clock_divider, i2s_rate;
	logic [7:0]  run_status;
	logic cfg_valid, cfg_last, cfg_ready, ctl_ready, fail_safe, booted_spi, mic_run, i2s_run;
	int n_mismatch = 0;
	int tests_run = 0;
	always #4 ref_clk = ~ref_clk;
	bcs_boot_seq #(.READY_LIMIT_CYC(50)) i_bcs_boot_seq (.ref_clk, .reset, .spi_boot_strap,
		.boot_source_select_pin, .usb_variant, .image_is_upgrade, .image_version, .image_bad,
		.hdr_valid, .hdr_compat_version, .cfg_valid, .cfg_code, .cfg_value, .cfg_last,
		.cfg_ready, .spi_image_done, .spi_image_bad, .ctl_valid, .ctl_code, .ctl_value,
		.ctl_ready, .run_status, .fail_safe, .booted_spi, .vendor_id, .product_id,
		.mic_clock_divider, .i2s_rate, .mic_run, .i2s_run);
	bcs_flash_model i_bcs_flash_model (.ref_clk, .reset, .start, .stall, .cfg_ready,
		.cfg_valid, .cfg_code, .cfg_value, .cfg_last);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic boot(input logic spi, input logic sel, input logic usb);
		@(posedge ref_clk);
		reset <= 1'b1;
		spi_boot_strap <= spi;
		boot_source_select_pin <= sel;
		usb_variant <= usb;
		tick(12);
		reset <= 1'b0;
		tick(6);
	endtask : boot
	// outcome wait is bounded; checks land mid-cycle, clear of the edge
	task automatic settle();
		for (int i = 0; i < 80 && run_status === RS_NONE; i++) tick(1);
		tick(3);
		#1;
	endtask : settle
	task automatic send(input logic [3:0] code, input logic [15:0] val);
		@(posedge ref_clk);
		ctl_valid <= 1'b1;
		ctl_code <= code;
		ctl_value <= val;
		#1;
		// ready is judged mid-cycle, so the edge that follows is the one that takes the command
		for (int i = 0; i < 9 && ctl_ready !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		check(16'(ctl_ready), 16'h0001);
		@(posedge ref_clk);
		ctl_valid <= 1'b0;
	endtask : send
	task automatic t_flash(input logic upg, input logic [15:0] cv, input logic stl,
		input logic [7:0] st, input logic [15:0] div, input logic [15:0] vid);
		boot(1'b0, 1'b0, 1'b0);
		image_is_upgrade <= upg;
		hdr_compat_version <= cv;
		stall <= stl;
		hdr_valid <= 1'b1;
		@(posedge ref_clk);
		hdr_valid <= 1'b0;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		settle();
		check(16'(run_status), 16'(st));
		check(mic_clock_divider, div);
		check(vendor_id, vid);
		check(16'(fail_safe), 16'(stl));
		check(16'(mic_run), 16'(!stl));
		check(i2s_rate, (cv == image_version && !stl) ? 16'h3E80 : I2S_RATE_RST);
		$display("flash boot test done");
	endtask : t_flash
	task automatic t_spi(input logic sel, input logic usb);
		boot(1'b1, sel, usb);
		tick(4);
		spi_image_done <= 1'b1;
		@(posedge ref_clk);
		spi_image_done <= 1'b0;
		settle();
		check(16'(run_status), 16'(RS_SPI_OK));
		check(i2s_rate, I2S_RATE_RST);
		check(16'(cfg_ready), 16'h0000);
		check(16'(mic_run), 16'(sel || usb));
		check(16'(booted_spi), 16'h0001);
		send(CMD_MIC_DIV, 16'h0003);
		send(CMD_I2S_RATE, 16'h3E80);
		send(CMD_PID, 16'h0777);
		send(CMD_MIC_GO, 16'h0001);
		tick(2);
		#1;
		check(16'(i2s_run), 16'(sel || usb));
		send(CMD_I2S_GO, 16'h0001);
		tick(2);
		#1;
		check(mic_clock_divider, 16'h0003);
		check(i2s_rate, usb ? I2S_RATE_RST : 16'h3E80);
		check(product_id, usb ? PID_DEFAULT : 16'h0777);
		check(16'(mic_run && i2s_run), 16'h0001);
		$display("spi boot test done");
	endtask : t_spi
	task automatic t_fail(input logic spi);
		boot(spi, 1'b0, 1'b0);
		if (spi)
			spi_image_bad <= 1'b1;
		else
			image_bad <= 1'b1;
		@(posedge ref_clk);
		spi_image_bad <= 1'b0;
		image_bad <= 1'b0;
		settle();
		check(16'(run_status), 16'(spi ? RS_FAIL_SPI : RS_FAIL_IMAGE));
		check(16'(fail_safe), 16'h0001);
		check(16'(ctl_ready), 16'h0000);
		check(product_id, PID_DEFAULT);
		check(16'(booted_spi), 16'(spi));
		$display("failed boot test done");
	endtask : t_fail
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		t_flash(1'b0, 16'h0573, 1'b0, RS_FACTORY_OK, 16'h0002, 16'h5A5A);
		t_flash(1'b1, 16'h0573, 1'b0, RS_UPGRADE_OK, 16'h0002, 16'h5A5A);
		t_flash(1'b0, 16'h0574, 1'b0, RS_FACTORY_DEFAULT, MIC_DIV_RST, VID_DEFAULT);
		t_flash(1'b1, 16'h0574, 1'b0, RS_UPGRADE_DEFAULT, MIC_DIV_RST, VID_DEFAULT);
		t_flash(1'b0, 16'h0573, 1'b1, RS_FAIL_TIMEOUT, MIC_DIV_RST, VID_DEFAULT);
		t_spi(1'b1, 1'b0);
		t_spi(1'b0, 1'b0);
		t_spi(1'b0, 1'b1);
		t_fail(1'b0);
		t_fail(1'b1);
		print_verdict();
	end
	// whole run is under 1500 cycles; this margin only catches a hang
	initial begin
		tick(5000);
		n_mismatch++;
		print_verdict();
	end
endmodule : tb
